// ### core/led_enable_pkg.sv
package led_enable_pkg;
	localparam logic [7:0] fault_readback_offset = 8'h0e;
	localparam logic [7:0] output_enable_offset = 8'h0f;
	localparam logic [7:0] dc_limit_config_offset = 8'h03;
	localparam int dc_limit_enable_bit = 0;
	localparam int code_width = 6;
	localparam int first_on_bit = 0;
	localparam int second_on_bit = 1;
	localparam logic [5:0] fault_code_reset = 6'h00;
	localparam logic [5:0] flash_setting_reset = 6'h28;
	localparam logic [1:0] enable_reset = 2'h0;
endpackage : led_enable_pkg

// ### core/input_sync.sv
`timescale 1ns/1ps
module input_sync (
	input wire logic core_clk, // block clock
	input wire logic reset_n, // async reset, active low
	input wire logic async_in, // pin level
	output logic sync_out // synchronised level
);
	logic stage1;
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			stage1 <= 1'b0;
			sync_out <= 1'b0;
		end else begin
			stage1 <= async_in;
			sync_out <= stage1;
		end
	end
endmodule : input_sync

// ### core/led_channel_enable_and_fault_readback.sv
// What this block does
// RULE1: on a dc limit fault, capture the second channel flash code; bits 7:6 reserved.
// RULE2: captured code is linear, 18.7 mA per count, copied unchanged.
// RULE3: enable bit 1 turns the second channel on; resets to zero.
// RULE4: enable bit 0 turns the first channel on; resets to zero.
// RULE5: host clears both bits, then sets both in one write to start both.
// RULE6: with first channel on, a write setting bit 1 is ignored.
// RULE7: with second channel on, a write setting bit 0 is ignored.
// RULE8: dc limit flag reports only when dc limiting is enabled in register 0x03.
// RULE9: second channel flash setting is a six bit code, 18.7 mA per count.
// RULE10: captured code holds until the next capture; reads leave it alone.
`timescale 1ns/1ps
module led_channel_enable_and_fault_readback
	import led_enable_pkg::*;
(
	input wire logic core_clk, // 25 MHz clock
	input wire logic reset_n, // async reset, active low
	input wire logic reg_write, // one-cycle register write strobe from the serial decoder
	input wire logic [7:0] reg_addr, // register address
	input wire logic [7:0] reg_wdata, // write data
	input wire logic [7:0] dc_limit_config, // configuration register 0x03 contents
	input wire logic [5:0] second_channel_flash_setting, // programmed second channel flash code
	input wire logic dc_limit_detect, // raw dc limit comparator, asynchronous pin
	output logic [7:0] reg_rdata, // read data for reg_addr
	output logic dc_limit_reached_flag, // dc limit status flag
	output logic first_channel_output_on, // first channel output enable
	output logic second_channel_output_on // second channel output enable
);
	////////////////////////////////////////////////////////////////////////////
	logic detect_sync;
	logic dc_limit_enabled;
	logic fault_event;
	logic [5:0] led2_fault_current_code;
	logic write_enable_reg;
	logic want_first;
	logic want_second;
	logic next_first;
	logic next_second;
	logic [7:0] next_rdata;

	// a set request survives unless only the other channel is already running
	function automatic logic set_allowed(input logic want, input logic own, input logic other);
		return want & ~(other & ~own);
	endfunction : set_allowed

	input_sync u_detect_sync (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.async_in(dc_limit_detect),
		.sync_out(detect_sync)
	);

	assign dc_limit_enabled = dc_limit_config[dc_limit_enable_bit];
	// capture on the rising edge of the gated flag, so a long fault stores one snapshot
	assign fault_event = detect_sync & dc_limit_enabled & ~dc_limit_reached_flag; // [RULE8]

	////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			dc_limit_reached_flag <= 1'b0;
		end else begin
			dc_limit_reached_flag <= detect_sync & dc_limit_enabled; // [RULE8]
		end
	end

	// the code is copied raw: its scale is the same 18.7 mA per count as the setting
	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			led2_fault_current_code <= fault_code_reset;
		end else if (fault_event) begin
			led2_fault_current_code <= second_channel_flash_setting; // [RULE1] [RULE2] [RULE9] [RULE10]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	assign write_enable_reg = reg_write && (reg_addr == output_enable_offset);
	assign want_first = reg_wdata[first_on_bit];
	assign want_second = reg_wdata[second_on_bit];
	// a set request is dropped while only the other channel already runs; clears always land
	assign next_second = set_allowed(want_second, second_channel_output_on, first_channel_output_on); // [RULE6] [RULE5]
	assign next_first = set_allowed(want_first, first_channel_output_on, second_channel_output_on); // [RULE7] [RULE5]

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			first_channel_output_on <= enable_reset[first_on_bit]; // [RULE4]
			second_channel_output_on <= enable_reset[second_on_bit]; // [RULE3]
		end else if (write_enable_reg) begin
			first_channel_output_on <= next_first; // [RULE4]
			second_channel_output_on <= next_second; // [RULE3]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// reads have no side effect; reserved bits and unmapped addresses read zero
	always_comb begin
		next_rdata = 8'h00;
		unique case (reg_addr)
			fault_readback_offset: next_rdata = {2'b00, led2_fault_current_code}; // [RULE1] [RULE10]
			output_enable_offset: next_rdata = {6'h00, second_channel_output_on, first_channel_output_on};
			default: next_rdata = 8'h00;
		endcase
	end

	always_ff @(posedge core_clk or negedge reset_n) begin
		if (!reset_n) begin
			reg_rdata <= 8'h00;
		end else begin
			reg_rdata <= next_rdata;
		end
	end
endmodule : led_channel_enable_and_fault_readback

// ### verification/led_chk.sv
`timescale 1ns/1ps
module led_chk (
	input logic core_clk, // clock
	input logic reset_n, // reset
	input logic reg_write, // strobe
	input logic [7:0] reg_addr, // address
	input logic [7:0] reg_wdata, // data
	input logic [7:0] dc_limit_config, // config
	input logic [7:0] reg_rdata, // read data
	input logic dc_limit_reached_flag, // flag
	input logic first_channel_output_on, // ch1
	input logic second_channel_output_on // ch2
);
	default clocking @(posedge core_clk); endclocking
	default disable iff (!reset_n);
	wire w = reg_write && reg_addr == 8'h0f;
	wire a = first_channel_output_on;
	wire b = second_channel_output_on;
	wire f = dc_limit_reached_flag;
	AST_C1: assert property (w && !b |=> a == $past(reg_wdata[0])) else $error("ch1 bad");
	AST_C2: assert property (w && !a |=> b == $past(reg_wdata[1])) else $error("ch2 bad");
	AST_B6: assert property (w && a && !b |=> !b) else $error("ch2 set");
	AST_B7: assert property (w && b && !a |=> !a) else $error("ch1 set");
	AST_RD: assert property ($past(reg_addr) == 8'h0f |-> reg_rdata == {6'h00, $past(b), $past(a)}) else $error("rd");
	AST_RSV: assert property ($past(reg_addr) == 8'h0e |-> reg_rdata[7:6] == 2'h0) else $error("rsv");
	AST_OFF: assert property (!dc_limit_config[0] |=> !f) else $error("flag");
	AST_HOLD: assert property (reg_addr == 8'h0e && $stable(reg_addr) && !$rose(f) |=> $stable(reg_rdata)) else $error("hold");
endmodule : led_chk
bind led_channel_enable_and_fault_readback led_chk chk (.*);

// ### verification/led_host.sv
`timescale 1ns/1ps
module led_host (
	input logic core_clk, // clock
	output logic reg_write, // write strobe
	output logic [7:0] reg_addr, // address
	output logic [7:0] reg_wdata // write data
);
	initial {reg_write, reg_addr, reg_wdata} = 17'h00000;
	task automatic xfer(input logic w, input logic [7:0] a, input logic [7:0] d);
		@(posedge core_clk);
		{reg_write, reg_addr, reg_wdata} <= {w, a, d}; // whole byte, both enables in one write
		@(posedge core_clk);
		reg_write <= 1'b0;
	endtask : xfer
endmodule : led_host

// ### verification/tb.sv
`timescale 1ns/1ps
module tb;
	logic core_clk = 1'b0, reset_n = 1'b0, dc_limit_detect = 1'b0, reg_write, dc_limit_reached_flag;
	logic first_channel_output_on, second_channel_output_on;
	logic [7:0] reg_addr, reg_wdata, reg_rdata, dc_limit_config = 8'h00;
	logic [5:0] second_channel_flash_setting = 6'h28;
	int error_cnt = 0;
	int comparisons = 0;
	// bits 23:21 hold the expected {flag, second, first} after each row
	logic [31:0] st [13] = '{32'h280f0000, 32'h283f0101, 32'h283f0301, 32'h281f0200, 32'h285f0202, 32'h285f0302,
		32'h281f0100, 32'h287f0303, 32'h287e3f00, 32'ha86e0000, 32'hfcee003c, 32'h686e003c, 32'he8ee0028};
	led_host host (.*);
	led_channel_enable_and_fault_readback dut (.*);
	initial forever #20 core_clk = ~core_clk;
	initial begin
		repeat (4) @(posedge core_clk);
		reset_n <= 1'b1;
	end
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		if (got !== exp) $display("[FAIL] %0t got %h expected %h", $time, got, exp);
		error_cnt += int'(got !== exp);
		comparisons += 1;
	endtask : chk
	task automatic give_verdict;
		if (error_cnt == 0 && comparisons > 0) $display("Finished cleanly");
		else $display("Finished with errors");
		$finish;
	endtask : give_verdict
	initial begin
		foreach (st[i]) begin
			@(posedge core_clk iff reset_n) {dc_limit_detect, dc_limit_config[0], second_channel_flash_setting} <= st[i][31:24];
			host.xfer(st[i][20], {4'h0, st[i][19:16]}, st[i][15:8]);
			repeat (3) @(posedge core_clk);
			#1 chk(reg_rdata, st[i][7:0]); // row
			chk({5'h00, dc_limit_reached_flag, second_channel_output_on, first_channel_output_on}, {5'h00, st[i][23:21]});
		end
		give_verdict();
	end
endmodule : tb
